// ==== verilog/port_f_pkg.sv ====
// Constants shared by the port F pin logic
package port_f_pkg;
  // Widths
  localparam int          PORT_W         = 8;
  localparam int          AXI_ADDR_W     = 4;
  localparam int          AXI_DATA_W     = 32;
  // Register byte offsets
  localparam logic [3:0]  OUTPUT_DATA_OFF = 4'h0;
  localparam logic [3:0]  PIN_STATE_OFF   = 4'h4;
  localparam logic [3:0]  DIRECTION_OFF   = 4'h8;
  localparam logic [3:0]  TRIG_SELECT_OFF = 4'hC;
  // Reset values
  localparam logic [7:0]  OUTPUT_DATA_RST = 8'h00;
  localparam logic [7:0]  DIRECTION_RST   = 8'h00;
  localparam logic [1:0]  TRIG_SELECT_RST = 2'h0;
  // Field positions
  localparam int          CLOCK_PIN      = 7;
  localparam int          IRQ_TWO_PIN    = 0;
  localparam int          IRQ_THREE_PIN  = 3;
  localparam int          TRIG_PIN       = 3;
  localparam int          TRIG_LOW_BIT   = 0;
  localparam int          TRIG_HIGH_BIT  = 1;
  // Trigger select value that routes pin 3 to the converter
  localparam logic [1:0]  TRIG_FROM_PIN  = 2'h3;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;
  // Register selection
  typedef enum logic [2:0] {SEL_OUT, SEL_STATE, SEL_DIR, SEL_TRIG, SEL_NONE} reg_sel_t;
endpackage : port_f_pkg

// ==== verilog/port_f_pin_if.sv ====
// Pin-side signals between the port core, the synchroniser and the drivers
`timescale 1ns/1ps
interface port_f_pin_if;
  logic [7:0] level;
  logic [7:0] dir;
  logic [7:0] data;
  logic [7:0] out;
  logic [7:0] oe;
  modport sync_mp  (output level);
  modport drive_mp (input dir, input data, output out, output oe);
  modport core_mp  (input level, output dir, output data, input out, input oe);
endinterface : port_f_pin_if

// ==== verilog/port_f_pin_sync.sv ====
// Two-stage synchroniser for the port F pin levels
`timescale 1ns/1ps
module port_f_pin_sync (
  // Clock
  input  wire logic       aclk,
  // Raw pins
  input  wire logic [7:0] pin_in,
  // Synchronised levels
  port_f_pin_if.sync_mp   pins
);
  logic [7:0] meta_r;
  logic [7:0] level_r;

  genvar i;
  generate
    for (i = 0; i < port_f_pkg::PORT_W; i++) begin : g_sync
      always_ff @(posedge aclk) begin
        meta_r[i]  <= pin_in[i];
        level_r[i] <= meta_r[i];
      end
    end
  endgenerate

  assign pins.level = level_r;
endmodule : port_f_pin_sync

// ==== verilog/port_f_pin_drive.sv ====
// Registered output and enable drivers for the port F pins
`timescale 1ns/1ps
module port_f_pin_drive (
  // Clock and reset
  input  wire logic     aclk,
  input  wire logic     aresetn,
  // Pin controls
  port_f_pin_if.drive_mp pins
);
  logic [7:0] out_r;
  logic [7:0] oe_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_r <= port_f_pkg::DIRECTION_RST;
    end else begin
      oe_r <= pins.dir;
    end
  end

  // Pin 7 carries the clock, so its data bit is never driven
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= port_f_pkg::OUTPUT_DATA_RST;
    end else begin
      out_r <= {1'b0, pins.data[6:0]};
    end
  end

  assign pins.out = out_r;
  assign pins.oe  = oe_r;
endmodule : port_f_pin_drive

// ==== verilog/port_f_gpio.sv ====
// Port F general-purpose pin logic with an AXI4-Lite register slave
`timescale 1ns/1ps
module port_f_gpio (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Port pins
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe,
  // Interrupt and converter trigger levels
  output logic             external_interrupt_two_n,
  output logic             external_interrupt_three_n,
  output logic             converter_external_trigger_n
);
  port_f_pin_if pins ();

  logic [7:0]  port_f_output_data_r;
  logic [7:0]  port_f_direction_r;
  logic [1:0]  trig_select_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  aw_addr_r;
  logic [7:0]  w_data_r;
  logic        w_lane_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        irq_two_r;
  logic        irq_three_r;
  logic        trig_r;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_write;
  logic        aw_got_nxt;
  logic        w_got_nxt;
  logic        bvalid_nxt;
  logic        rvalid_nxt;
  logic [7:0]  pin_state;
  port_f_pkg::reg_sel_t wr_sel;
  port_f_pkg::reg_sel_t rd_sel;

  // Register decode shared by reads and writes
  function automatic port_f_pkg::reg_sel_t decode(input logic [3:0] addr);
    case (addr)
      port_f_pkg::OUTPUT_DATA_OFF: decode = port_f_pkg::SEL_OUT;
      port_f_pkg::PIN_STATE_OFF:   decode = port_f_pkg::SEL_STATE;
      port_f_pkg::DIRECTION_OFF:   decode = port_f_pkg::SEL_DIR;
      port_f_pkg::TRIG_SELECT_OFF: decode = port_f_pkg::SEL_TRIG;
      default:                     decode = port_f_pkg::SEL_NONE;
    endcase
  endfunction : decode

  port_f_pin_sync u_sync (
    .aclk   (aclk),
    .pin_in (pin_in),
    .pins   (pins.sync_mp)
  );

  port_f_pin_drive u_drive (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (pins.drive_mp)
  );

  assign pins.dir  = port_f_direction_r;
  assign pins.data = port_f_output_data_r;

  // Write channel handshakes
  assign aw_take    = s_axi_awvalid & awready_r;
  assign w_take     = s_axi_wvalid & wready_r;
  assign do_write   = aw_got_r & w_got_r & ~bvalid_r;
  assign aw_got_nxt = aw_got_r ? ~do_write : aw_take;
  assign w_got_nxt  = w_got_r ? ~do_write : w_take;
  assign bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);
  assign wr_sel     = decode(aw_addr_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
    end else begin
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      awready_r <= ~aw_got_nxt & ~bvalid_nxt;
      wready_r  <= ~w_got_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= 4'h0;
      w_data_r  <= 8'h00;
      w_lane_r  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_r <= port_f_pkg::RESP_OKAY;
    end else if (do_write) begin
      bresp_r <= (wr_sel == port_f_pkg::SEL_NONE) ? port_f_pkg::RESP_DECERR : port_f_pkg::RESP_OKAY;
    end
  end

  // Output data keeps bit 7 exactly as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_f_output_data_r <= port_f_pkg::OUTPUT_DATA_RST;
    end else if (do_write && w_lane_r && wr_sel == port_f_pkg::SEL_OUT) begin
      port_f_output_data_r <= w_data_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_f_direction_r <= port_f_pkg::DIRECTION_RST;
    end else if (do_write && w_lane_r && wr_sel == port_f_pkg::SEL_DIR) begin
      port_f_direction_r <= w_data_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_select_r <= port_f_pkg::TRIG_SELECT_RST;
    end else if (do_write && w_lane_r && wr_sel == port_f_pkg::SEL_TRIG) begin
      trig_select_r <= w_data_r[1:0];
    end
  end

  // Read channel
  assign ar_take    = s_axi_arvalid & arready_r;
  assign rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
  assign rd_sel     = decode(s_axi_araddr);
  assign pin_state  = (port_f_direction_r & port_f_output_data_r) |
                      (~port_f_direction_r & pins.level);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
    end
  end

  // Direction is write-only and reads as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= 32'h0000_0000;
      rresp_r <= port_f_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rresp_r <= port_f_pkg::RESP_OKAY;
      case (rd_sel)
        port_f_pkg::SEL_OUT:   rdata_r <= {24'h00_0000, port_f_output_data_r};
        port_f_pkg::SEL_STATE: rdata_r <= {24'h00_0000, pin_state};
        port_f_pkg::SEL_TRIG:  rdata_r <= {30'h0000_0000, trig_select_r};
        port_f_pkg::SEL_DIR:   rdata_r <= 32'h0000_0000;
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= port_f_pkg::RESP_DECERR;
        end
      endcase
    end
  end

  // Interrupt levels taken from synchronised pins; trigger from pin 3 only while TRIG_FROM_PIN is selected, else held high
  always_ff @(posedge aclk) begin
    irq_two_r   <= pins.level[port_f_pkg::IRQ_TWO_PIN];
    irq_three_r <= pins.level[port_f_pkg::IRQ_THREE_PIN];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_r <= 1'b1;
    end else if (trig_select_r == port_f_pkg::TRIG_FROM_PIN) begin
      trig_r <= pins.level[port_f_pkg::TRIG_PIN];
    end else begin
      trig_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign pin_oe        = pins.oe;
  // Pin 7 forwards the system clock while enabled
  assign pin_out       = {pins.oe[port_f_pkg::CLOCK_PIN] & aclk, pins.out[6:0]};
  assign external_interrupt_two_n     = irq_two_r;
  assign external_interrupt_three_n   = irq_three_r;
  assign converter_external_trigger_n = trig_r;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence out_write_s;
    do_write && w_lane_r && wr_sel == port_f_pkg::SEL_OUT;
  endsequence

  sequence state_read_s;
    ar_take && rd_sel == port_f_pkg::SEL_STATE;
  endsequence

  out_write_store_a: assert property (out_write_s |=> port_f_output_data_r == $past(w_data_r))
    else $error("output data not stored");
  bit7_kept_a: assert property (out_write_s |=> port_f_output_data_r[7] == $past(w_data_r[7]))
    else $error("bit 7 not stored as written");
  state_ro_a: assert property (do_write && wr_sel == port_f_pkg::SEL_STATE |=>
    $stable(port_f_output_data_r) && $stable(port_f_direction_r))
    else $error("pin state write had effect");
  state_pins_a: assert property (do_write && wr_sel == port_f_pkg::SEL_STATE |=> ##1
    $stable(pin_oe) && $stable(pin_out[6:0]))
    else $error("pin state write moved pins");
  read_out_a: assert property (state_read_s |=>
    (rdata_r[7:0] & $past(port_f_direction_r)) == ($past(port_f_output_data_r) & $past(port_f_direction_r)))
    else $error("output pin read not from data");
  read_pin_a: assert property (state_read_s |=>
    (rdata_r[7:0] & ~$past(port_f_direction_r)) == ($past(pins.level) & ~$past(port_f_direction_r)))
    else $error("input pin read not from level");
  clock_pin_a: assert property (port_f_direction_r[7] |=> pin_oe[7])
    else $error("pin 7 not enabled");
  clock_out_a: assert property (@(negedge aclk) pin_out[7] == pin_oe[7])
    else $error("pin 7 clock not forwarded");
  pin0_drive_a: assert property (1'b1 |=> pin_oe[0] == $past(port_f_direction_r[0]) &&
    pin_out[0] == $past(port_f_output_data_r[0]))
    else $error("pin 0 drive wrong");
  drive_pins_a: assert property (1'b1 |=> pin_oe[6:1] == $past(port_f_direction_r[6:1]) &&
    pin_out[6:1] == $past(port_f_output_data_r[6:1]))
    else $error("pins 6..1 drive wrong");
  irq_two_a: assert property (##3 external_interrupt_two_n == $past(pin_in[0], 3))
    else $error("interrupt two level wrong");
  irq_three_a: assert property (##3 external_interrupt_three_n == $past(pin_in[3], 3))
    else $error("interrupt three level wrong");
  trig_pin_a: assert property (trig_select_r == port_f_pkg::TRIG_FROM_PIN |=> trig_r == $past(pins.level[3]))
    else $error("trigger not from pin 3");
  trig_idle_a: assert property (trig_select_r != port_f_pkg::TRIG_FROM_PIN |=> trig_r)
    else $error("trigger active while deselected");
  dir_reset_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> port_f_direction_r == 8'h00)
    else $error("direction not cleared by reset");
endmodule : port_f_gpio

// ==== tb/port_f_board.sv ====
// Board-side model of the signals at the port F pins
`timescale 1ns/1ps
module port_f_board (
  // Device pin drivers
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Level the board puts on undriven pins
  input  wire logic [7:0] ext_level,
  // Level seen at each pin
  output logic      [7:0] pin_in
);
  // Driven pins show the device value, released pins the board level
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : port_f_board

// ==== tb/port_f_gpio_tb_top.sv ====
// Self-checking testbench for the port F pin logic
`timescale 1ns/1ps
module port_f_gpio_tb_top;
  logic        aclk, aresetn;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  pin_in, pin_out, pin_oe, ext_level;
  logic        irq_two_n, irq_three_n, trig_n;
  logic [31:0] rd_d;
  logic [1:0]  rsp;
  int          bad_count, checks;

  port_f_gpio u_port_f_gpio (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .external_interrupt_two_n(irq_two_n),
    .external_interrupt_three_n(irq_three_n), .converter_external_trigger_n(trig_n));

  port_f_board u_port_f_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic expire();
    bad_count++;
    $display("BAD %0t bus wait ran out", $time);
    end_sim();
  endtask : expire

  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    int n;
    aw_done = 0;
    w_done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (!(aw_done && w_done)) expire();
    for (n = 0; n < 50; n++) begin
      if (n > 0 || !s_axi_bvalid) @(posedge aclk);
      if (s_axi_bvalid) break;
    end
    if (s_axi_bvalid !== 1'b1) expire();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (s_axi_rvalid !== 1'b1) expire();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic reset_values();
    rd(port_f_pkg::OUTPUT_DATA_OFF, rd_d, rsp);
    check(rd_d, 32'h00000000);
    rd(port_f_pkg::DIRECTION_OFF, rd_d, rsp);
    check(rd_d, 32'h00000000);
    check({24'h000000, pin_oe}, 32'h00000000);
  endtask : reset_values

  task automatic data_rw();
    wr(port_f_pkg::OUTPUT_DATA_OFF, 8'h5A, rsp);
    check({30'h0, rsp}, {30'h0, port_f_pkg::RESP_OKAY});
    rd(port_f_pkg::OUTPUT_DATA_OFF, rd_d, rsp);
    check(rd_d, 32'h0000005A);
    // Bit 7 kept at zero by software
    wr(port_f_pkg::OUTPUT_DATA_OFF, 8'h7F, rsp);
    rd(port_f_pkg::OUTPUT_DATA_OFF, rd_d, rsp);
    check(rd_d, 32'h0000007F);
  endtask : data_rw

  task automatic state_ro();
    ext_level <= 8'h3C;
    wr(port_f_pkg::PIN_STATE_OFF, 8'hFF, rsp);
    check({30'h0, rsp}, {30'h0, port_f_pkg::RESP_OKAY});
    repeat (4) @(posedge aclk);
    rd(port_f_pkg::PIN_STATE_OFF, rd_d, rsp);
    check(rd_d, 32'h0000003C);
    check({24'h000000, pin_oe}, 32'h00000000);
    rd(port_f_pkg::OUTPUT_DATA_OFF, rd_d, rsp);
    check(rd_d, 32'h0000007F);
  endtask : state_ro

  task automatic input_read();
    logic [7:0] lv [2];
    lv = '{8'hA9, 8'h56};
    for (int i = 0; i < 2; i++) begin
      ext_level <= lv[i];
      repeat (4) @(posedge aclk);
      rd(port_f_pkg::PIN_STATE_OFF, rd_d, rsp);
      check(rd_d, {24'h000000, lv[i]});
      check({31'h0, irq_two_n}, {31'h0, lv[i][0]});
      check({31'h0, irq_three_n}, {31'h0, lv[i][3]});
    end
  endtask : input_read

  task automatic output_read();
    wr(port_f_pkg::DIRECTION_OFF, 8'h76, rsp);
    wr(port_f_pkg::OUTPUT_DATA_OFF, 8'h2A, rsp);
    ext_level <= 8'hC3;
    repeat (4) @(posedge aclk);
    check({24'h000000, pin_oe}, 32'h00000076);
    check({25'h0, pin_out[6:0]}, 32'h0000002A);
    rd(port_f_pkg::PIN_STATE_OFF, rd_d, rsp);
    check(rd_d, 32'h000000A3);
  endtask : output_read

  task automatic clock_out();
    wr(port_f_pkg::DIRECTION_OFF, 8'h80, rsp);
    repeat (2) @(posedge aclk);
    check({24'h000000, pin_oe}, 32'h00000080);
    #2 check({31'h0, pin_out[7]}, 32'h00000001);
    #5 check({31'h0, pin_out[7]}, 32'h00000000);
    @(posedge aclk);
    wr(port_f_pkg::DIRECTION_OFF, 8'h00, rsp);
    repeat (2) @(posedge aclk);
    check({31'h0, pin_oe[7]}, 32'h00000000);
  endtask : clock_out

  task automatic trigger_sel();
    ext_level <= 8'h00;
    for (int v = 0; v < 4; v++) begin
      wr(port_f_pkg::TRIG_SELECT_OFF, 8'(v), rsp);
      repeat (4) @(posedge aclk);
      check({31'h0, trig_n}, (v == 3) ? 32'h00000000 : 32'h00000001);
    end
    ext_level <= 8'h08;
    repeat (4) @(posedge aclk);
    check({31'h0, trig_n}, 32'h00000001);
  endtask : trigger_sel

  task automatic unmapped();
    wr(4'h2, 8'h11, rsp);
    check({30'h0, rsp}, {30'h0, port_f_pkg::RESP_DECERR});
    rd(4'h2, rd_d, rsp);
    check({30'h0, rsp}, {30'h0, port_f_pkg::RESP_DECERR});
    rd(port_f_pkg::OUTPUT_DATA_OFF, rd_d, rsp);
    check(rd_d, 32'h0000002A);
  endtask : unmapped

  initial begin
    bad_count = 0;
    checks = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    ext_level = 8'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_values();
    data_rw();
    state_ro();
    input_read();
    output_read();
    clock_out();
    trigger_sel();
    unmapped();
    end_sim();
  end
endmodule : port_f_gpio_tb_top
